// File: core/sapc_regs.svh
`ifndef SAPC_REGS_SVH
`define SAPC_REGS_SVH

// =====================================================
// Timing counts, in half periods of the conversion clock.
`define SAPC_CONV_HALVES 5'd27
`define SAPC_SAMPLE_HALVES 5'd5
// First half of the doubled bit 5 decision, and first half of the last decision.
`define SAPC_BIT5_FIRST 5'd12
`define SAPC_LSB_FIRST 5'd24
`define SAPC_RESULT_W 12
`define SAPC_CHAN_W 3
`define SAPC_PWR_NORMAL 2'h0
`define SAPC_PWR_NAP 2'h1
`define SAPC_PWR_SLEEP 2'h2
`endif

// File: core/sapc_pkg.sv
`include "sapc_regs.svh"
package sapc_pkg;
  // Host strobe and address group, sampled synchronously; CS_N and RD_N also drive RESULT_OE_N without a register.
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic [2:0] addr;
  } sapc_host_t;
  // Conversion sequencer states, one-hot.
  typedef enum logic [2:0] {
    SAPC_IDLE = 3'h1,
    SAPC_WAIT = 3'h2,
    SAPC_CONV = 3'h4
  } sapc_state_t;
endpackage

// File: core/sapc_sar.sv
`include "sapc_regs.svh"
// =====================================================
// Successive-approximation register: one bit per decision step.
module sapc_sar
  import sapc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic step,
  input wire logic [3:0] bit_idx,
  input wire logic comp_hi,
  output logic [11:0] code
);
  // All state in one struct.
  typedef struct packed {
    logic [11:0] trial;
  } sapc_sar_st_t;
  sapc_sar_st_t st;
  sapc_sar_st_t next_st;

  // Keep or drop the tried bit, then try the next lower one.
  always_comb begin
    next_st = st;
    if (start) begin
      next_st.trial = 12'h800;
    end else if (step) begin
      next_st.trial[bit_idx] = comp_hi;
      if (bit_idx != 4'h0) begin
        next_st.trial[bit_idx - 4'h1] = 1'b1;
      end
    end
  end

  // Registered state; the clock enable freezes it.
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign code = st.trial;
endmodule // sapc_sar

// File: core/sapc_top.sv
`include "sapc_regs.svh"
// =====================================================
// Converter control and parallel host port.
module sapc_top
  import sapc_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic CONV_CLK,
  input wire logic CS_N,
  input wire logic WR_N,
  input wire logic RD_N,
  input wire logic [2:0] CHANNEL_SEL,
  input wire logic COMP_HI,
  output logic BUSY_N,
  output logic [11:0] RESULT,
  output logic RESULT_OE_N,
  output logic [2:0] ACTIVE_CHANNEL,
  output logic NAP,
  output logic SLEEP,
  output logic SAMPLING
);
  // =====================================================
  // State.
  typedef struct packed {
    sapc_state_t fsm;
    logic wr_q;
    logic rd_q;
    logic cclk_q;
    logic [4:0] half;
    logic [2:0] chan;
    logic [1:0] pwr;
    logic [11:0] result;
  } sapc_st_t;
  sapc_st_t st;
  sapc_st_t next_st;
  sapc_host_t host;
  logic wr_fall; // Convert strobe went low with select low.
  logic wr_rise; // Convert strobe released.
  logic rd_rise; // Read strobe released.
  logic cclk_rise; // Conversion clock rose.
  logic cclk_edge; // Conversion clock changed either way.
  logic sar_step; // One bit decision completes.
  logic [3:0] bit_idx; // Bit under decision.
  logic [11:0] sar_code; // Running approximation.

  // Edge detectors compare each pin with its value one clock earlier. Their reset
  // values equal the idle pin levels, so no false edge follows reset.
  // The conversion clock is sampled as data, so it must run much slower than CLK;
  // each of its edges is then seen exactly once.
  assign host = '{cs_n: CS_N, wr_n: WR_N, rd_n: RD_N, addr: CHANNEL_SEL};
  assign wr_fall = st.wr_q && !host.wr_n && !host.cs_n;
  assign wr_rise = !st.wr_q && host.wr_n && !host.cs_n;
  assign rd_rise = !st.rd_q && host.rd_n && !host.cs_n;
  assign cclk_rise = !st.cclk_q && CONV_CLK;
  assign cclk_edge = st.cclk_q != CONV_CLK;

  // Last half period of a conversion; the sequencer and the step logic both need it.
  function automatic logic last_half(input logic [4:0] half);
    last_half = (half == `SAPC_CONV_HALVES - 5'd1);
  endfunction

  // Decision timing in half clocks: bits 11 to 6 take two halves each, bit 5 four,
  // bits 4 to 1 two each and the last decision three, 27 halves in all.
  // The step pulse marks the conversion clock edge that closes each decision, so
  // the comparator is read once per bit and never twice for the same bit.
  always_comb begin
    bit_idx = 4'h0;
    sar_step = 1'b0;
    if (st.fsm == SAPC_CONV && cclk_edge) begin
      if (st.half < `SAPC_BIT5_FIRST) begin
        // Halves 0 to 11: bit 11 closes at half 1, bit 6 at half 11.
        bit_idx = 4'd11 - 4'(st.half[4:1]);
        sar_step = st.half[0];
      end else if (st.half < `SAPC_BIT5_FIRST + 5'd4) begin
        // Halves 12 to 15: the doubled decision for bit 5.
        bit_idx = 4'd5;
        sar_step = (st.half == `SAPC_BIT5_FIRST + 5'd3);
      end else if (st.half < `SAPC_LSB_FIRST) begin
        // Halves 16 to 23: bits 4 to 1 close on the odd halves.
        bit_idx = 4'd4 - 4'((st.half - `SAPC_BIT5_FIRST - 5'd4) >> 1);
        sar_step = st.half[0];
      end else begin
        // Halves 24 to 26: the last decision takes one and a half cycles.
        bit_idx = 4'd0;
        sar_step = last_half(st.half);
      end
    end
  end

  // Sequencer, channel latch and power state.
  // A start in the same cycle as a read release wins: the start clears the power
  // state, since a new conversion always leaves power-down.
  always_comb begin
    next_st = st;
    next_st.wr_q = host.wr_n;
    next_st.rd_q = host.rd_n;
    next_st.cclk_q = CONV_CLK;
    if (wr_rise) begin
      next_st.chan = host.addr;
    end
    if (rd_rise && st.fsm == SAPC_IDLE) begin
      // Address bit 2 is ignored; bit 1 wins over bit 0.
      if (host.addr[1]) begin
        next_st.pwr = `SAPC_PWR_SLEEP;
      end else if (host.addr[0]) begin
        next_st.pwr = `SAPC_PWR_NAP;
      end else begin
        next_st.pwr = `SAPC_PWR_NORMAL;
      end
    end
    case (st.fsm)
      SAPC_IDLE: begin
        if (wr_fall) begin
          next_st.fsm = SAPC_WAIT;
          next_st.pwr = `SAPC_PWR_NORMAL;
        end
      end
      SAPC_WAIT: begin
        if (cclk_rise) begin
          next_st.fsm = SAPC_CONV;
          next_st.half = 5'd0;
        end
      end
      SAPC_CONV: begin
        if (cclk_edge) begin
          if (last_half(st.half)) begin
            next_st.fsm = SAPC_IDLE;
            next_st.result = sar_code;
            next_st.result[0] = COMP_HI;
          end else begin
            next_st.half = st.half + 5'd1;
          end
        end
      end
      default: begin
        next_st.fsm = SAPC_IDLE;
      end
    endcase
  end

  // Registered state; the clock enable freezes everything.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st <= '{fsm: SAPC_IDLE, wr_q: 1'b1, rd_q: 1'b1, cclk_q: 1'b0, half: 5'd0,
              chan: 3'h0, pwr: `SAPC_PWR_NORMAL, result: 12'h000};
    end else if (CE) begin
      st <= next_st;
    end
  end

  // The approximation register lives in its own module.
  sapc_sar u_sar (
    .clk(CLK),
    .rst(SYS_RST),
    .ce(CE),
    .start(wr_fall && st.fsm == SAPC_IDLE),
    .step(sar_step),
    .bit_idx(bit_idx),
    .comp_hi(COMP_HI),
    .code(sar_code)
  );

  // =====================================================
  // Outputs. Busy covers both the wait for the clock and the conversion.
  assign BUSY_N = (st.fsm == SAPC_IDLE);
  assign RESULT = st.result;
  assign RESULT_OE_N = CS_N | RD_N;
  assign ACTIVE_CHANNEL = st.chan;
  assign NAP = (st.pwr == `SAPC_PWR_NAP);
  assign SLEEP = (st.pwr == `SAPC_PWR_SLEEP);
  // Sampling fills the idle time and the wait for the clock at normal power only, not in nap or sleep; 2.5 + 13.5 cycles make one period.
  assign SAMPLING = (st.fsm != SAPC_CONV) && (st.pwr == `SAPC_PWR_NORMAL);

  // =====================================================
  // Checks.
  // They watch what the block drives; host pins also appear in the consequents of a_oe_gate and a_chan_latch.
  a_busy_rise: assert property (@(posedge CLK) disable iff (SYS_RST)
    $rose(BUSY_N) |-> ($past(st.fsm) == SAPC_CONV && $past(st.half) == 5'd26))
    else $error("busy rose before the conversion ended");
  a_start_busy: assert property (@(posedge CLK) disable iff (SYS_RST)
    (CE && wr_fall && BUSY_N) |=> !BUSY_N) else $error("start did not lower busy");
  a_wait_rise: assert property (@(posedge CLK) disable iff (SYS_RST)
    (CE && st.fsm == SAPC_WAIT && cclk_rise) |=> st.fsm == SAPC_CONV)
    else $error("conversion not entered on clock rise");
  a_conv_len: assert property (@(posedge CLK) disable iff (SYS_RST)
    (CE && st.fsm == SAPC_CONV && cclk_edge && st.half == 5'd26) |=> BUSY_N)
    else $error("conversion length wrong");
  a_result_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
    (BUSY_N && $past(BUSY_N)) |-> $stable(RESULT)) else $error("result moved while idle");
  a_oe_gate: assert property (@(posedge CLK) disable iff (SYS_RST)
    !RESULT_OE_N |-> (!CS_N && !RD_N)) else $error("bus enabled without strobes");
  a_sleep_sel: assert property (@(posedge CLK) disable iff (SYS_RST)
    (CE && rd_rise && BUSY_N && !wr_fall && CHANNEL_SEL[1]) |=> SLEEP)
    else $error("sleep not taken");
  a_wake_conv: assert property (@(posedge CLK) disable iff (SYS_RST)
    (CE && wr_fall && BUSY_N) |=> !NAP && !SLEEP) else $error("power-down not left");
  a_chan_latch: assert property (@(posedge CLK) disable iff (SYS_RST)
    (CE && wr_rise) |=> ACTIVE_CHANNEL == $past(CHANNEL_SEL)) else $error("channel not latched");
  a_chan_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
    !(CE && wr_rise) |=> $stable(ACTIVE_CHANNEL))
    else $error("channel moved without a strobe");
  a_oe_open: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!CS_N && !RD_N) |-> !RESULT_OE_N) else $error("bus not enabled by the strobes");
  a_nap_sel: assert property (@(posedge CLK) disable iff (SYS_RST)
    (CE && rd_rise && BUSY_N && !wr_fall && CHANNEL_SEL[1:0] == 2'h1) |=> NAP)
    else $error("nap not taken");
  a_normal_sel: assert property (@(posedge CLK) disable iff (SYS_RST)
    (CE && rd_rise && BUSY_N && CHANNEL_SEL[1:0] == 2'h0) |=> (!NAP && !SLEEP))
    else $error("normal operation not restored");
  a_pwr_busy: assert property (@(posedge CLK) disable iff (SYS_RST)
    (CE && !BUSY_N) |=> $stable(st.pwr)) else $error("power state moved while busy");
  a_conv_keep: assert property (@(posedge CLK) disable iff (SYS_RST)
    (CE && st.fsm == SAPC_CONV && !last_half(st.half)) |=> st.fsm == SAPC_CONV)
    else $error("conversion cut short");
  a_ce_freeze: assert property (@(posedge CLK) disable iff (SYS_RST)
    !CE |=> $stable(st)) else $error("state moved with the clock enable low");
endmodule // sapc_top

// File: tb/sapc_far_model.sv
// =====================================================
// Analog side: free running conversion clock and a comparator.
module sapc_far_model (
  output logic conv_clk,
  output logic comp_hi,
  input wire logic level
);
  timeunit 1ns;
  timeprecision 1ps;
  // The conversion clock runs free at 6.25 MHz, far slower than the system clock.
  initial begin
    conv_clk = 1'b0;
  end
  // Half period of 80 ns, above the 50 ns minimum high and low times.
  always begin
    #80 conv_clk = ~conv_clk;
  end
  // The input sits below or above every trial level, so all decisions agree.
  // This trades mid codes for a model that needs no view of the trial value.
  assign comp_hi = level;
endmodule // sapc_far_model

// File: tb/testbench.sv
// =====================================================
// Host bench for the converter control block.
module testbench;
  import sapc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cs_n = 1'b1;
  logic wr_n = 1'b1;
  logic rd_n = 1'b1;
  logic [2:0] sel = 3'h0;
  logic level = 1'b0;
  logic ce = 1'b1;
  logic conv_clk, comp_hi, busy_n, oe_n, nap, sleep, samp;
  logic [11:0] result;
  logic [2:0] act;
  int fails = 0;
  int num_checks = 0;
  int n;
  // The system clock has an 8 ns period.
  always begin
    #4 clk = ~clk;
  end
  sapc_far_model u_sapc_far_model (.conv_clk(conv_clk), .comp_hi(comp_hi), .level(level));
  sapc_top u_sapc_top (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .CONV_CLK(conv_clk),
    .CS_N(cs_n), .WR_N(wr_n), .RD_N(rd_n), .CHANNEL_SEL(sel), .COMP_HI(comp_hi),
    .BUSY_N(busy_n), .RESULT(result), .RESULT_OE_N(oe_n), .ACTIVE_CHANNEL(act),
    .NAP(nap), .SLEEP(sleep), .SAMPLING(samp));
  // =====================================================
  // Compare and report.
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // =====================================================
  // One conversion on a channel, then a read that picks a power state.
  task automatic convert_read(input logic [2:0] ch, input logic [1:0] pw);
    @(negedge clk);
    cs_n = 1'b0;
    wr_n = 1'b0;
    sel = ch;
    @(negedge clk);
    wr_n = 1'b1;
    @(negedge clk);
    check(12'(busy_n), 12'h0);
    check(12'({nap, sleep}), 12'h0);
    // Bounded wait; the conversion spans 27 conversion clock edges.
    for (n = 0; n < 400 && busy_n !== 1'b1; n++) begin
      @(negedge clk);
    end
    if (n == 400) begin
      fails++;
      finish_test;
    end
    check(12'(n >= 250 && n <= 295), 12'h1);
    check(result, ch[0] ? 12'hfff : 12'h000);
    check(12'(act), 12'(ch));
    check(12'(oe_n), 12'h1);
    rd_n = 1'b0;
    sel = {1'b0, pw};
    @(negedge clk);
    check(12'(oe_n), 12'h0);
    check(result, ch[0] ? 12'hfff : 12'h000);
    rd_n = 1'b1;
    @(negedge clk);
    @(negedge clk);
    check(12'({nap, sleep}), pw == 2'h0 ? 12'h0 : pw == 2'h1 ? 12'h2 : 12'h1);
    check(12'(samp), 12'(pw == 2'h0));
    sel = 3'h0;
  endtask
  // =====================================================
  // Main sequence.
  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check(12'({busy_n, oe_n, nap, sleep}), 12'hc);
    check(result, 12'h000);
    check(12'({act, samp}), 12'h1);
    // A strobe with the chip deselected must not start anything.
    wr_n = 1'b0;
    @(negedge clk);
    wr_n = 1'b1;
    @(negedge clk);
    @(negedge clk);
    check(12'(busy_n), 12'h1);
    // With the clock enable low a selected strobe must not be seen either.
    ce = 1'b0;
    cs_n = 1'b0;
    wr_n = 1'b0;
    @(negedge clk);
    wr_n = 1'b1;
    @(negedge clk);
    ce = 1'b1;
    @(negedge clk);
    @(negedge clk);
    check(12'(busy_n), 12'h1);
    // Every channel, both code extremes and every power code. The model has no
    // reference that must settle, so results after sleep are compared as well.
    for (int i = 0; i < 8; i++) begin
      level = i[0];
      convert_read(3'(i), 2'(i));
    end
    // The last read left the block asleep; with no strobes it must stay so.
    repeat (400) @(negedge clk);
    check(12'(sleep), 12'h1);
    finish_test;
  end
endmodule // testbench
